// ---- design/iasq_pkg.sv ----
// Purpose: Shared constants, types and states of the indirect access sequencer
// Assumes: 8-bit host port, 125 MHz device clock
// Notes: Positions marked as chosen are listed for verification separately
package iasq_pkg;
	// Direct port decode
	localparam logic PORT_DIRECT = 1'b0;
	localparam logic PORT_INDIRECT = 1'b1;
	// Indirect register locations
	localparam logic [7:0] LOC_CFG = 8'hFE;
	localparam logic [7:0] LOC_CSR = 8'hFF;
	// Control byte field positions
	localparam int CTL_TSEL_HI = 5;
	localparam int CTL_TSEL_LO = 4;
	localparam int CTL_AUX_HI = 1;
	localparam int CTL_AUX_LO = 0;
	localparam logic [7:0] CTL_UNUSED_ONES = 8'hCC;
	localparam logic [1:0] AUX_REG_READ = 2'h3;
	localparam logic [1:0] TSEL_REG = 2'h3;
	localparam logic [1:0] TSEL_CM_READ = 2'h0;
	// Configuration read-back and standard mode bit
	localparam logic [7:0] CFG_TOP_ONES = 8'hFC;
	localparam int CFG_STD_BIT = 0;
	localparam logic [7:0] CFG_RESET = 8'h01;
	localparam logic [7:0] CSR_RESET = 8'h00;
	localparam logic [7:0] SETUP_RESET = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
	// Operating setup and condition bit positions
	localparam int SETUP_CANCEL_BIT = 0;
	localparam int COND_CLEAR_BIT = 7;
	localparam int COND_BUSY_BIT = 6;
	localparam int COND_LOSS_BIT = 5;
	// Connection memory shape
	localparam int CM_DEPTH = 256;
	localparam int CM_WORD_W = 10;
	// Access time and its cycle count, rounded down
	localparam int ACCESS_TIME_NS = 900;
	localparam int CLK_PERIOD_NS = 8;
	localparam int ACCESS_CYC = ACCESS_TIME_NS / CLK_PERIOD_NS;
	// Host pins sampled on the device clock
	typedef struct packed {
		logic cs_b;
		logic wr_b;
		logic rd_b;
		logic port_sel;
		logic [7:0] wdata;
	} iasq_bus_t;
	// Sequencer states
	typedef enum logic [7:0] {
		S_WCTL = 8'h01,
		S_WDAT = 8'h02,
		S_WLOC = 8'h04,
		S_EXEC = 8'h08,
		S_RCTL = 8'h10,
		S_RDAT = 8'h20,
		S_RLOC = 8'h40,
		S_RINIT = 8'h80
	} iasq_state_t;
endpackage

// ---- design/iasq_top.sv ----
// Purpose: Indirect access sequencer of an 8-bit host port with connection memory
// Assumes: Host pins synchronous to ref_clk; rst_b synchronous, active low
// Notes: Strobe falling edges take bytes; reads load the data flip-flop
// How it works
// - Indirect port takes control byte, then data byte, then location byte.
// - Both select bits set means indirect register; else memory, read when both zero.
// - Busy set on first byte; access done within 900 ns, then busy cleared.
// - Setup and condition registers stay reachable while a transfer is pending.
// - Setting the cancel bit in the setup register abandons the transfer.
// - For register transfers control bit 0 high reads, low writes.
// - Location FE is configuration register, FF is clock shift register.
// - Memory write stores control bits 1..0 above the data byte.
// - Location byte is memory address, or picks the indirect register.
// - Read request fetches value into data byte, memory reads also update aux bits.
// - First read sets busy; bytes return in order, select and location unchanged.
// - After third read byte the sequencer reinitialises within 900 ns, clearing busy.
// - Control bits 7, 6, 3 and 2 read back as one.
// - Register read-backs return control bits 1 and 0 as one.
// - Condition register holds clear, busy and loss flags; bits 4..0 read zero.
// - Configuration read-back returns its six top bits as one.
// - Clock shift applies only in primary access mode, zero in standard mode.
// - Select 0 writes setup, reads condition; select 1 is the indirect port.
// - Connection memory holds 256 words of 10 bits.
`timescale 1ns/10ps
module iasq_top #(
	parameter int ACC_CYC = iasq_pkg::ACCESS_CYC, // Cycles per access or reinit
	parameter int CNT_W = 8 // Width of the access counter
) (
	input wire logic ref_clk, // Device clock
	input wire logic rst_b, // Synchronous reset, active low
	input wire iasq_pkg::iasq_bus_t host_bus, // Host strobes, select and write data
	input wire logic mem_clear_busy, // Memory clear in progress
	input wire logic data_loss_warn, // Data loss condition seen
	input wire logic [7:0] cm_rd_addr, // Switching read address
	output logic [7:0] host_rdata, // Read data to host
	output logic host_rdata_oe, // Drive enable of the data bus
	output logic [7:0] operating_setup, // Operating setup register value
	output logic [7:0] configuration, // Configuration register value
	output logic [7:0] clock_shift, // Effective clock shift value
	output logic [9:0] cm_rd_data // Switching read word
);
	import iasq_pkg::*;

	// Parameter checks
	generate
		if (ACC_CYC < 1 || ACC_CYC >= (1 << CNT_W))
		begin : g_bad_cyc
			$error("ACC_CYC out of range for CNT_W");
		end
	endgenerate

	// Decode helpers for the control byte
	function automatic logic is_reg_xfer(input logic [7:0] ctl);
		is_reg_xfer = ({ctl[CTL_TSEL_HI], ctl[CTL_TSEL_LO]} == TSEL_REG);
	endfunction

	function automatic logic is_read_xfer(input logic [7:0] ctl);
		if (is_reg_xfer(ctl))
			is_read_xfer = ctl[CTL_AUX_LO];
		else
			is_read_xfer = ({ctl[CTL_TSEL_HI], ctl[CTL_TSEL_LO]} == TSEL_CM_READ);
	endfunction

	iasq_state_t state_r;
	iasq_state_t state_nxt;
	logic wr_b_prev_r;
	logic rd_b_prev_r;
	logic [CNT_W-1:0] cnt_r;
	logic [7:0] ctl_r;
	logic [7:0] data_r;
	logic [7:0] loc_r;
	logic [7:0] setup_r;
	logic [7:0] cfg_r;
	logic [7:0] csr_r;
	logic [CM_WORD_W-1:0] cm_r [CM_DEPTH];
	logic [7:0] rdata_r;
	logic wr_start;
	logic rd_start;
	logic ind_wr;
	logic ind_rd;
	logic setup_wr;
	logic abort;
	logic cnt_done;
	logic exec_fire;
	logic busy;
	logic [7:0] cond_val;
	logic [7:0] ctl_rb;
	logic [7:0] ind_byte;

	// Strobe edge detection history, sampled every cycle whether selected or not
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			wr_b_prev_r <= 1'b1;
			rd_b_prev_r <= 1'b1;
		end
		else
		begin
			wr_b_prev_r <= host_bus.wr_b;
			rd_b_prev_r <= host_bus.rd_b;
		end
	end

	// Access decode
	assign wr_start = !host_bus.cs_b && wr_b_prev_r && !host_bus.wr_b;
	assign rd_start = !host_bus.cs_b && rd_b_prev_r && !host_bus.rd_b;
	assign ind_wr = wr_start && (host_bus.port_sel == PORT_INDIRECT);
	assign ind_rd = rd_start && (host_bus.port_sel == PORT_INDIRECT);
	assign setup_wr = wr_start && (host_bus.port_sel == PORT_DIRECT);
	assign abort = setup_wr && host_bus.wdata[SETUP_CANCEL_BIT];
	assign cnt_done = (cnt_r == '0);
	assign exec_fire = (state_r == S_EXEC) && cnt_done && !abort;

	// Sequencer next state
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			S_WCTL: if (ind_wr) state_nxt = S_WDAT;
			S_WDAT: if (ind_wr) state_nxt = S_WLOC;
			S_WLOC: if (ind_wr) state_nxt = S_EXEC;
			S_EXEC: if (cnt_done) state_nxt = is_read_xfer(ctl_r) ? S_RCTL : S_WCTL;
			S_RCTL: if (ind_rd) state_nxt = S_RDAT;
			S_RDAT: if (ind_rd) state_nxt = S_RLOC;
			S_RLOC: if (ind_rd) state_nxt = S_RINIT;
			S_RINIT: if (cnt_done) state_nxt = S_WCTL;
			default: state_nxt = S_WCTL;
		endcase
		if (abort)
			state_nxt = S_WCTL;
	end

	// Sequencer state
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			state_r <= S_WCTL;
		else
			state_r <= state_nxt;
	end

	// Access and reinit countdown
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			cnt_r <= '0;
		else if (state_nxt != state_r)
			cnt_r <= CNT_W'(ACC_CYC - 1);
		else if (!cnt_done)
			cnt_r <= cnt_r - 1'b1;
	end

	// Busy while a byte sequence or access is pending
	assign busy = (state_r != S_WCTL) && (state_r != S_RCTL);

	// Indirect port bytes
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			ctl_r <= BYTE_ZERO;
			data_r <= BYTE_ZERO;
			loc_r <= BYTE_ZERO;
		end
		else if (exec_fire && is_read_xfer(ctl_r)) // Fetch wins over a stray write
		begin
			if (!is_reg_xfer(ctl_r))
			begin
				data_r <= cm_r[loc_r][7:0];
				ctl_r[CTL_AUX_HI:CTL_AUX_LO] <= cm_r[loc_r][9:8];
			end
			else if (loc_r == LOC_CFG)
				data_r <= cfg_r | CFG_TOP_ONES;
			else if (loc_r == LOC_CSR)
				data_r <= clock_shift;
		end
		else if (ind_wr && !abort)
		begin
			if (state_r == S_WCTL)
				ctl_r <= host_bus.wdata;
			if (state_r == S_WDAT)
				data_r <= host_bus.wdata;
			if (state_r == S_WLOC)
				loc_r <= host_bus.wdata;
		end
	end

	// Indirect register writes
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
		begin
			cfg_r <= CFG_RESET;
			csr_r <= CSR_RESET;
		end
		else if (exec_fire && is_reg_xfer(ctl_r) && !ctl_r[CTL_AUX_LO])
		begin
			if (loc_r == LOC_CFG)
				cfg_r <= data_r;
			if (loc_r == LOC_CSR)
				csr_r <= data_r;
		end
	end

	// Connection memory write port
	always_ff @(posedge ref_clk)
	begin
		if (exec_fire && !is_reg_xfer(ctl_r) && !is_read_xfer(ctl_r))
			cm_r[loc_r] <= {ctl_r[CTL_AUX_HI:CTL_AUX_LO], data_r};
	end

	// Connection memory switching read port
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			cm_rd_data <= '0;
		else
			cm_rd_data <= cm_r[cm_rd_addr];
	end

	// Operating setup register, writable at any time
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			setup_r <= SETUP_RESET;
		else if (setup_wr)
			setup_r <= host_bus.wdata;
	end

	// Condition value and control read-back
	always_comb
	begin
		cond_val = BYTE_ZERO;
		cond_val[COND_CLEAR_BIT] = mem_clear_busy;
		cond_val[COND_BUSY_BIT] = busy;
		cond_val[COND_LOSS_BIT] = data_loss_warn;
		ctl_rb = ctl_r | CTL_UNUSED_ONES;
		if (is_reg_xfer(ctl_r))
			ctl_rb[CTL_AUX_HI:CTL_AUX_LO] = AUX_REG_READ;
		unique case (state_r)
			S_RDAT: ind_byte = data_r;
			S_RLOC: ind_byte = loc_r;
			default: ind_byte = ctl_rb;
		endcase
	end

	// Read data latched at the start of each read strobe
	always_ff @(posedge ref_clk)
	begin
		if (!rst_b)
			rdata_r <= BYTE_ZERO;
		else if (ind_rd)
			rdata_r <= ind_byte;
		else if (rd_start)
			rdata_r <= cond_val;
	end

	// Outputs
	assign host_rdata = rdata_r;
	assign host_rdata_oe = !host_bus.cs_b && !host_bus.rd_b;
	assign operating_setup = setup_r;
	assign configuration = cfg_r;
	assign clock_shift = cfg_r[CFG_STD_BIT] ? CSR_RESET : csr_r;
endmodule

// ---- verification/iasq_host.sv ----
// Purpose: Host processor model on the 8-bit port
// Assumes: Pins change at the falling clock edge
// Notes: Idle data bus shows the inverse of the last byte
`timescale 1ns/10ps
module iasq_host (
	input wire logic ref_clk, // Clock
	input wire logic [7:0] host_rdata, // Read data
	output iasq_pkg::iasq_bus_t host_bus // Host pins
);
	import iasq_pkg::*;
	initial host_bus = '{1'b1, 1'b1, 1'b1, 1'b0, 8'h00};
	// One write, then an idle cycle with both strobes high
	task automatic wr(input logic cs_b, input logic sel, input logic [7:0] d);
		@(negedge ref_clk);
		host_bus = '{cs_b, 1'b0, 1'b1, sel, d};
		@(negedge ref_clk);
		host_bus = '{1'b1, 1'b1, 1'b1, sel, ~d};
	endtask
	// One read, data taken a cycle and a half after the take edge
	task automatic rd(input logic sel, output logic [7:0] d);
		@(negedge ref_clk);
		host_bus = '{1'b0, 1'b1, 1'b0, sel, ~host_bus.wdata};
		@(negedge ref_clk);
		@(negedge ref_clk);
		d = host_rdata;
		host_bus = '{1'b1, 1'b1, 1'b1, sel, ~host_bus.wdata};
	endtask
endmodule

// ---- verification/iasq_top_sva.sv ----
// Purpose: Port checks of the indirect access sequencer
// Assumes: Only the top module's ports are seen
// Notes: Bound to iasq_top below
`timescale 1ns/10ps
module iasq_top_sva #(
	parameter int ACC_CYC = 4, // Access cycles
	parameter int CNT_W = 8 // Counter width
) (
	input wire logic ref_clk, // Clock
	input wire logic rst_b, // Reset
	input wire iasq_pkg::iasq_bus_t host_bus, // Host pins
	input wire logic mem_clear_busy, // Clear flag
	input wire logic data_loss_warn, // Loss flag
	input wire logic [7:0] cm_rd_addr, // Switch address
	input wire logic [7:0] host_rdata, // Read data
	input wire logic host_rdata_oe, // Bus enable
	input wire logic [7:0] operating_setup, // Setup value
	input wire logic [7:0] configuration, // Config value
	input wire logic [7:0] clock_shift, // Shift value
	input wire logic [9:0] cm_rd_data // Switch word
);
	import iasq_pkg::*;
	logic wr_prev_r, rd_prev_r, wr_e, rd_e;
	// Strobe history, high out of reset
	always_ff @(posedge ref_clk)
	begin
		wr_prev_r <= !rst_b | host_bus.wr_b;
		rd_prev_r <= !rst_b | host_bus.rd_b;
	end
	// Strobe take edges
	assign wr_e = !host_bus.cs_b && !host_bus.wr_b && wr_prev_r;
	assign rd_e = !host_bus.cs_b && !host_bus.rd_b && rd_prev_r;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	sequence s_setup_wr; wr_e && !host_bus.port_sel; endsequence
	sequence s_cond_rd; rd_e && !host_bus.port_sel; endsequence
	chk_oe_strobes: assert property (host_rdata_oe == (!host_bus.cs_b && !host_bus.rd_b))
		else $error("bus enable wrong");
	chk_setup_take: assert property (s_setup_wr |=> operating_setup == $past(host_bus.wdata))
		else $error("setup not taken");
	chk_setup_hold: assert property (!(wr_e && !host_bus.port_sel) |=> $stable(operating_setup))
		else $error("setup changed");
	chk_cond_zero: assert property (s_cond_rd |=> host_rdata[4:0] == 5'h00)
		else $error("condition low bits");
	chk_cond_flags: assert property (s_cond_rd |=> host_rdata[COND_CLEAR_BIT] ==
		$past(mem_clear_busy) && host_rdata[COND_LOSS_BIT] == $past(data_loss_warn))
		else $error("condition flags");
	chk_rdata_hold: assert property (!rd_e |=> $stable(host_rdata))
		else $error("read data moved");
	chk_shift_std: assert property (configuration[CFG_STD_BIT] |-> clock_shift == BYTE_ZERO)
		else $error("shift in standard");
	chk_reset_vals: assert property ($rose(rst_b) |-> operating_setup == SETUP_RESET &&
		configuration == CFG_RESET && clock_shift == CSR_RESET)
		else $error("reset values");
endmodule
bind iasq_top iasq_top_sva #(.ACC_CYC(ACC_CYC), .CNT_W(CNT_W)) chk_u (.ref_clk(ref_clk),
	.rst_b(rst_b), .host_bus(host_bus), .mem_clear_busy(mem_clear_busy),
	.data_loss_warn(data_loss_warn), .cm_rd_addr(cm_rd_addr), .host_rdata(host_rdata),
	.host_rdata_oe(host_rdata_oe), .operating_setup(operating_setup),
	.configuration(configuration), .clock_shift(clock_shift), .cm_rd_data(cm_rd_data));

// ---- verification/iasq_top_tb.sv ----
// Purpose: Self-checking bench of the indirect access sequencer
// Assumes: Short access count of 4 cycles
// Notes: Random memory words with fixed corner cases
`timescale 1ns/10ps
module iasq_top_tb;
	import iasq_pkg::*;
	logic ref_clk = 1'b0;
	logic rst_b = 1'b0;
	logic mem_clear_busy = 1'b0;
	logic data_loss_warn = 1'b0;
	logic [7:0] cm_rd_addr = 8'h00;
	iasq_bus_t host_bus;
	logic [7:0] host_rdata, operating_setup, configuration, clock_shift, b, a;
	logic [9:0] cm_rd_data, w;
	logic [1:0] k;
	logic host_rdata_oe;
	int mismatches = 0;
	int check_count = 0;
	iasq_host host_u (.ref_clk(ref_clk), .host_rdata(host_rdata), .host_bus(host_bus));
	iasq_top #(.ACC_CYC(4)) dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .host_bus(host_bus),
		.mem_clear_busy(mem_clear_busy), .data_loss_warn(data_loss_warn),
		.cm_rd_addr(cm_rd_addr), .host_rdata(host_rdata), .host_rdata_oe(host_rdata_oe),
		.operating_setup(operating_setup), .configuration(configuration),
		.clock_shift(clock_shift), .cm_rd_data(cm_rd_data));
	always #4 ref_clk = ~ref_clk;
	// Verdict and end of run
	task automatic results();
		if (mismatches == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// Compare one value
	task automatic chk(input string n, input logic [9:0] e, input logic [9:0] s);
		check_count++;
		if (s !== e)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	// Expected control read-back byte
	function automatic logic [7:0] ctl_rb(input logic [7:0] c, input logic [1:0] x);
		return CTL_UNUSED_ONES | (c & 8'h30) | {6'h00, x};
	endfunction
	// Poll condition until busy drops
	task automatic idle();
		int n;
		n = 0;
		do
		begin
			host_u.rd(PORT_DIRECT, b);
			n++;
		end
		while (b[COND_BUSY_BIT] !== 1'b0 && n < 40);
		chk("busy_end", 10'h000, 10'(b[COND_BUSY_BIT]));
	endtask
	// Three-byte indirect write
	task automatic xfer(input logic [7:0] c, input logic [7:0] d, input logic [7:0] l);
		host_u.wr(1'b0, PORT_INDIRECT, c);
		host_u.wr(1'b0, PORT_INDIRECT, d);
		host_u.wr(1'b0, PORT_INDIRECT, l);
		idle();
	endtask
	// Three read-back bytes
	task automatic back(input logic [7:0] c, input logic [7:0] d, input logic [7:0] l);
		host_u.rd(PORT_INDIRECT, b);
		chk("rb_ctl", 10'(c), 10'(b));
		host_u.rd(PORT_INDIRECT, b);
		chk("rb_data", 10'(d), 10'(b));
		host_u.rd(PORT_INDIRECT, b);
		chk("rb_loc", 10'(l), 10'(b));
		idle();
	endtask
	// Switching read of one word
	task automatic cm_chk(input logic [7:0] ad, input logic [9:0] e);
		cm_rd_addr = ad;
		@(negedge ref_clk);
		@(negedge ref_clk);
		chk("cm_word", e, cm_rd_data);
	endtask
	initial
	begin
		void'($urandom(32545));
		repeat (6) @(negedge ref_clk);
		rst_b = 1'b1;
		chk("cfg_reset", 10'(CFG_RESET), 10'(configuration));
		a = 8'($urandom) & 8'hFE;
		host_u.wr(1'b0, PORT_DIRECT, a);
		host_u.wr(1'b1, PORT_DIRECT, ~a);
		chk("setup", 10'(a), 10'(operating_setup));
		repeat (4)
		begin
			{mem_clear_busy, data_loss_warn} = 2'($urandom);
			host_u.rd(PORT_DIRECT, b);
			chk("cond", 10'({mem_clear_busy, 1'b0, data_loss_warn, 5'h00}), 10'(b));
		end
		{mem_clear_busy, data_loss_warn} = 2'h0;
		xfer(8'h30, 8'h55, LOC_CSR);
		chk("shift_std", 10'h000, 10'(clock_shift));
		xfer(8'h30, 8'h00, LOC_CFG);
		chk("cfg", 10'h000, 10'(configuration));
		chk("shift_pa", 10'h055, 10'(clock_shift));
		xfer(8'h31, 8'($urandom), LOC_CFG);
		back(8'hFF, 8'hFC, LOC_CFG);
		xfer(8'h33, 8'($urandom), LOC_CSR);
		back(8'hFF, 8'h55, LOC_CSR);
		for (int i = 0; i < 6; i++)
		begin
			w = (i == 0) ? 10'h200 : 10'($urandom);
			a = (i == 0) ? 8'hAA : 8'($urandom);
			k = (i == 0) ? 2'h1 : 2'($urandom_range(2, 1));
			xfer({2'h0, k, 2'h0, w[9:8]}, w[7:0], a);
			cm_chk(a, w);
			b = 8'($urandom) & 8'hCF;
			xfer(b, 8'($urandom), a);
			back(ctl_rb(b, w[9:8]), w[7:0], a);
		end
		host_u.wr(1'b0, PORT_INDIRECT, 8'h10);
		host_u.rd(PORT_DIRECT, b);
		chk("busy_set", 10'h001, 10'(b[COND_BUSY_BIT]));
		host_u.wr(1'b0, PORT_INDIRECT, 8'h3F);
		host_u.wr(1'b0, PORT_DIRECT, 8'h01);
		host_u.wr(1'b0, PORT_DIRECT, 8'h00);
		idle();
		xfer(8'h11, 8'h23, 8'h07);
		cm_chk(8'h07, 10'h123);
		results();
	end
	// Watchdog against a hang
	initial
	begin
		#100000;
		mismatches++;
		results();
	end
endmodule
